// ===== rtl/dsfs_pkg.sv
package dsfs_pkg;

    // object dictionary addresses of the two objects
    localparam logic [15:0] DSFS_IDX_SUBMODE = 16'h3202;
    localparam logic [15:0] DSFS_IDX_FBSEL = 16'h3203;
    localparam logic [7:0] DSFS_SUB_ZERO = 8'h00;
    localparam logic [7:0] DSFS_SUB_COUNT = 8'h00;
    localparam logic [7:0] DSFS_SUB_FIRST = 8'h01;

    // feedback count and reset values
    localparam int DSFS_NUM_FB = 4;
    localparam logic [31:0] DSFS_SUBMODE_RST = 32'h0000_0000;
    localparam logic [7:0] DSFS_MASK_RST = 8'h00;

    // submode word bit positions
    localparam int DSFS_SM_LOOP = 0;
    localparam int DSFS_SM_RAMP = 1;
    localparam int DSFS_SM_BRAKE = 2;
    localparam int DSFS_SM_CURRENT_REDUCE = 3;
    localparam int DSFS_SM_ALIGN = 4;
    localparam int DSFS_SM_TORQUE = 5;
    localparam int DSFS_SM_BLDC = 6;
    localparam int DSFS_SM_SLOW = 7;

    // feedback mask bit positions
    localparam int DSFS_FB_POS = 0;
    localparam int DSFS_FB_VEL = 1;
    localparam int DSFS_FB_COMM = 2;

    // sensor numbers are 1-based, sensor 1 is the sensorless feedback
    localparam int DSFS_SEL_W = 8;
    localparam logic [7:0] DSFS_SENSORLESS = 8'h01;
    localparam int DSFS_SCAN_FIRST = 2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] subidx;
        logic [31:0] wdata;
    } dsfs_od_req_type;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dsfs_od_rsp_type;

    typedef struct packed {
        logic loop_closed;
        logic ramp_speed_sim;
        logic brake_auto;
        logic current_reduce;
        logic torque_only;
        logic velocity_superimpose;
        logic bldc;
        logic slow_speed;
    } dsfs_mode_type;

    typedef struct packed {
        logic [7:0] pos;
        logic [7:0] vel;
        logic [7:0] comm;
    } dsfs_fb_src_type;

    typedef enum logic [1:0] {
        DSFS_ST_OPEN = 2'b00,
        DSFS_ST_ALIGN = 2'b01,
        DSFS_ST_WAIT_INDEX = 2'b10,
        DSFS_ST_CLOSED = 2'b11
    } dsfs_comm_state_type;

endpackage : dsfs_pkg

// ===== rtl/dsfs_prio_scan.sv
`timescale 1ns/10ps

module dsfs_prio_scan
    import dsfs_pkg::*;
#(
    parameter int NUM_FB = DSFS_NUM_FB
) (
    // one hit bit per sensor, bit 0 is sensor 1
    input wire logic [NUM_FB-1:0] hit_i,
    // chosen sensor number
    output logic [DSFS_SEL_W-1:0] sel_o
);

    logic found;

    always_comb begin
        sel_o = DSFS_SENSORLESS;
        found = 1'b0;
        for (int i = DSFS_SCAN_FIRST - 1; i < NUM_FB; i++) begin
            if (!found && hit_i[i]) begin
                sel_o = DSFS_SEL_W'(i + 1);
                found = 1'b1;
            end
        end
    end

endmodule : dsfs_prio_scan

// ===== rtl/dsfs_top.sv
`timescale 1ns/10ps

module dsfs_top
    import dsfs_pkg::*;
#(
    parameter int NUM_FB = DSFS_NUM_FB
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,

    // object dictionary access
    input wire dsfs_od_req_type od_req_i,
    output dsfs_od_rsp_type od_rsp_o,

    // drive state and neighbouring logic
    input wire logic op_enabled_i,
    input wire logic torque_mode_i,
    input wire logic comm_has_index_i,
    input wire logic index_seen_i,
    input wire logic align_done_i,

    // resulting modes
    output dsfs_mode_type mode_o,
    output logic align_req_o,

    // chosen feedback sources
    output dsfs_fb_src_type fb_src_o
);

    // register state
    logic [31:0] submode_q;
    logic [31:0] submode_d;
    logic [NUM_FB-1:0][7:0] mask_shadow_q;
    logic [NUM_FB-1:0][7:0] mask_shadow_d;
    logic [NUM_FB-1:0][7:0] mask_active_q;
    logic [NUM_FB-1:0][7:0] mask_active_d;
    dsfs_od_rsp_type rsp_q;
    dsfs_od_rsp_type rsp_d;

    // decode helpers
    logic hit_submode;
    logic hit_count;
    logic hit_mask;
    logic [7:0] slot;

    // drive state tracking
    logic op_en_q;
    logic loop_eff_q;
    logic loop_eff_d;
    dsfs_comm_state_type state_q;
    dsfs_comm_state_type state_d;

    // outputs
    dsfs_mode_type mode_q;
    dsfs_mode_type mode_d;
    logic align_q;
    logic align_d;
    dsfs_fb_src_type src_q;
    dsfs_fb_src_type src_d;

    // scanner wiring
    logic [NUM_FB-1:0] pos_hit;
    logic [NUM_FB-1:0] vel_hit;
    logic [NUM_FB-1:0] comm_hit;
    logic [DSFS_SEL_W-1:0] pos_sel;
    logic [DSFS_SEL_W-1:0] vel_sel;
    logic [DSFS_SEL_W-1:0] comm_sel;
    logic closed_run;

    assign closed_run = (state_q == DSFS_ST_CLOSED);

    // address decode
    always_comb begin
        hit_submode = (od_req_i.index == DSFS_IDX_SUBMODE) &&
                      (od_req_i.subidx == DSFS_SUB_ZERO);
        hit_count = (od_req_i.index == DSFS_IDX_FBSEL) &&
                    (od_req_i.subidx == DSFS_SUB_COUNT);
        hit_mask = (od_req_i.index == DSFS_IDX_FBSEL) &&
                   (od_req_i.subidx >= DSFS_SUB_FIRST) &&
                   (od_req_i.subidx <= 8'(NUM_FB));
        slot = od_req_i.subidx - DSFS_SUB_FIRST;
    end

    // register file; a write has priority over a read in the same cycle
    always_comb begin
        submode_d = submode_q;
        mask_shadow_d = mask_shadow_q;
        rsp_d.ack = 1'b0;
        rsp_d.err = 1'b0;
        rsp_d.rdata = rsp_q.rdata;
        if (od_req_i.wr) begin
            rsp_d.ack = 1'b1;
            if (hit_submode) begin
                submode_d = od_req_i.wdata;
            end else if (hit_mask) begin
                // held in the shadow, taken over on entry to enabled
                mask_shadow_d[slot[1:0]] = od_req_i.wdata[7:0];
            end else begin
                // count entry is read only, others unmapped
                rsp_d.err = 1'b1;
            end
        end else if (od_req_i.rd) begin
            rsp_d.ack = 1'b1;
            rsp_d.rdata = '0;
            if (hit_submode) begin
                rsp_d.rdata = submode_q;
            end else if (hit_count) begin
                rsp_d.rdata = 32'(NUM_FB);
            end else if (hit_mask) begin
                rsp_d.rdata = {24'h00_0000, mask_shadow_q[slot[1:0]]};
            end else begin
                rsp_d.err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            submode_q <= DSFS_SUBMODE_RST;
            mask_shadow_q <= {NUM_FB{DSFS_MASK_RST}};
            rsp_q <= '0;
        end else begin
            submode_q <= submode_d;
            mask_shadow_q <= mask_shadow_d;
            rsp_q <= rsp_d;
        end
    end

    // active masks and effective loop selection
    always_comb begin
        mask_active_d = mask_active_q;
        // only the rising edge of enabled loads new masks
        if (op_enabled_i && !op_en_q) begin
            mask_active_d = mask_shadow_q;
        end
        // loop bit is sampled only while not enabled
        loop_eff_d = loop_eff_q;
        if (!op_enabled_i) begin
            loop_eff_d = submode_q[DSFS_SM_LOOP];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mask_active_q <= {NUM_FB{DSFS_MASK_RST}};
            op_en_q <= 1'b0;
            loop_eff_q <= 1'b0;
        end else begin
            mask_active_q <= mask_active_d;
            op_en_q <= op_enabled_i;
            loop_eff_q <= loop_eff_d;
        end
    end

    // commutation start-up sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            DSFS_ST_OPEN: begin
                if (op_enabled_i && loop_eff_q) begin
                    // no index on the encoder forces alignment
                    if (submode_q[DSFS_SM_ALIGN] || !comm_has_index_i) begin
                        state_d = DSFS_ST_ALIGN;
                    end else begin
                        state_d = DSFS_ST_WAIT_INDEX;
                    end
                end
            end
            DSFS_ST_ALIGN: begin
                if (!loop_eff_q) begin
                    state_d = DSFS_ST_OPEN;
                end else if (align_done_i) begin
                    state_d = DSFS_ST_CLOSED;
                end
            end
            DSFS_ST_WAIT_INDEX: begin
                if (!loop_eff_q) begin
                    state_d = DSFS_ST_OPEN;
                end else if (index_seen_i) begin
                    state_d = DSFS_ST_CLOSED;
                end
            end
            DSFS_ST_CLOSED: begin
                // alignment is kept until open loop is chosen again
                if (!loop_eff_q) begin
                    state_d = DSFS_ST_OPEN;
                end
            end
            default: begin
                state_d = DSFS_ST_OPEN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= DSFS_ST_OPEN;
        end else begin
            state_q <= state_d;
        end
    end

    // mode outputs
    always_comb begin
        mode_d.loop_closed = closed_run;
        mode_d.ramp_speed_sim = submode_q[DSFS_SM_RAMP];
        mode_d.brake_auto = submode_q[DSFS_SM_BRAKE];
        // alignment and index wait also run open loop
        mode_d.current_reduce = submode_q[DSFS_SM_CURRENT_REDUCE] && !closed_run;
        mode_d.torque_only = torque_mode_i && submode_q[DSFS_SM_TORQUE];
        mode_d.velocity_superimpose = torque_mode_i &&
                                      !submode_q[DSFS_SM_TORQUE];
        mode_d.bldc = submode_q[DSFS_SM_BLDC];
        // slow speed is held off until closed loop really runs
        mode_d.slow_speed = submode_q[DSFS_SM_SLOW] && closed_run;
        align_d = (state_d == DSFS_ST_ALIGN);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mode_q <= '0;
            align_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            align_q <= align_d;
        end
    end

    // per-sensor mask bits; entry 1 is the sensorless feedback
    always_comb begin
        for (int i = 0; i < NUM_FB; i++) begin
            pos_hit[i] = mask_active_q[i][DSFS_FB_POS];
            vel_hit[i] = mask_active_q[i][DSFS_FB_VEL];
            comm_hit[i] = mask_active_q[i][DSFS_FB_COMM];
        end
    end

    dsfs_prio_scan #(
        .NUM_FB(NUM_FB)
    ) u_scan_pos (
        .hit_i(pos_hit),
        .sel_o(pos_sel)
    );

    dsfs_prio_scan #(
        .NUM_FB(NUM_FB)
    ) u_scan_vel (
        .hit_i(vel_hit),
        .sel_o(vel_sel)
    );

    dsfs_prio_scan #(
        .NUM_FB(NUM_FB)
    ) u_scan_comm (
        .hit_i(comm_hit),
        .sel_o(comm_sel)
    );

    always_comb begin
        src_d.pos = pos_sel;
        src_d.vel = vel_sel;
        // open loop commutates sensorless, mask bit has no meaning
        src_d.comm = loop_eff_q ? comm_sel : DSFS_SENSORLESS;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            src_q <= {DSFS_SENSORLESS, DSFS_SENSORLESS, DSFS_SENSORLESS};
        end else begin
            src_q <= src_d;
        end
    end

    assign od_rsp_o = rsp_q;
    assign mode_o = mode_q;
    assign align_req_o = align_q;
    assign fb_src_o = src_q;

endmodule : dsfs_top

// ===== dv/dsfs_chk.sv
`timescale 1ns/10ps
module dsfs_chk
    import dsfs_pkg::*;
#(
    parameter int NUM_FB = DSFS_NUM_FB
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register port
    input wire dsfs_od_req_type od_req_i,
    input wire dsfs_od_rsp_type od_rsp_o,
    // drive side
    input wire logic op_enabled_i,
    input wire logic torque_mode_i,
    input wire logic comm_has_index_i,
    input wire logic index_seen_i,
    input wire logic align_done_i,
    input wire dsfs_mode_type mode_o,
    input wire logic align_req_o,
    input wire dsfs_fb_src_type fb_src_o
);
    default clocking dck @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_sub_wr;
        od_req_i.wr && od_req_i.index == DSFS_IDX_SUBMODE && od_req_i.subidx == DSFS_SUB_ZERO;
    endsequence
    sequence s_align_end;
        !align_req_o ##1 mode_o.loop_closed;
    endsequence
    a_ack_follows_req: assert property ((od_req_i.wr || od_req_i.rd) |=> od_rsp_o.ack)
        else $error("request without ack");
    a_err_has_ack: assert property (od_rsp_o.err |-> od_rsp_o.ack)
        else $error("err without ack");
    a_sub_copy: assert property (s_sub_wr |-> ##2
        mode_o.bldc == $past(od_req_i.wdata[6], 2)
        && mode_o.ramp_speed_sim == $past(od_req_i.wdata[1], 2)
        && mode_o.brake_auto == $past(od_req_i.wdata[2], 2)) else $error("submode bits wrong");
    a_torque_split: assert property ($past(rst_n_i) |->
        (mode_o.torque_only ^ mode_o.velocity_superimpose) == $past(torque_mode_i))
        else $error("torque loop split wrong");
    a_align_start: assert property ($rose(align_req_o) |-> $past(op_enabled_i))
        else $error("alignment outside enable");
    a_align_close: assert property (align_req_o && align_done_i |=> s_align_end)
        else $error("alignment did not close loop");
    a_slow_gate: assert property (mode_o.slow_speed |-> mode_o.loop_closed)
        else $error("slow speed in open loop");
    a_current_reduce_gate: assert property (mode_o.current_reduce |-> !mode_o.loop_closed)
        else $error("current reduction in closed loop");
    // masks only move on entry into the enabled state
    a_fb_hold: assert property (!$stable({fb_src_o.pos, fb_src_o.vel}) |->
        $past(op_enabled_i, 2) && !$past(op_enabled_i, 3)) else $error("sources moved");
endmodule : dsfs_chk

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import dsfs_pkg::*;
    logic clk_sys_i;
    logic rst_n_i;
    dsfs_od_req_type od_req_i;
    dsfs_od_rsp_type od_rsp_o;
    logic op_enabled_i, torque_mode_i, comm_has_index_i, index_seen_i, align_done_i;
    dsfs_mode_type mode_o;
    logic align_req_o;
    dsfs_fb_src_type fb_src_o;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    dsfs_top #(.NUM_FB(DSFS_NUM_FB)) i_dsfs_top (.clk_sys_i, .rst_n_i, .od_req_i, .od_rsp_o,
        .op_enabled_i, .torque_mode_i, .comm_has_index_i, .index_seen_i, .align_done_i,
        .mode_o, .align_req_o, .fb_src_o);

    initial begin
        clk_sys_i = 1'h0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // wd doubles as expected read data, which is zero on a refused read
    task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, input logic er);
        od_req_i = '{wr, !wr, idx, sub, wd};
        step(1);
        od_req_i = '0;
        chk({od_rsp_o.ack, od_rsp_o.err}, {1'h1, er});
        if (!wr) begin
            chk(od_rsp_o.rdata, er ? 32'h0 : wd);
        end
        // idle cycle: no back-to-back strobe, and a loop bit reaches the selection
        step(1);
    endtask : od

    task automatic wsm(input logic [31:0] d);
        od(1'h1, DSFS_IDX_SUBMODE, 8'h00, d, 1'h0);
    endtask : wsm

    task automatic wfb(input logic [7:0] k, input logic [31:0] d);
        od(1'h1, DSFS_IDX_FBSEL, k, d, 1'h0);
    endtask : wfb

    task automatic enable(input logic en);
        op_enabled_i = en;
        step(4);
    endtask : enable

    task automatic t_regs();
        od(1'h0, DSFS_IDX_FBSEL, 8'h00, 32'h4, 1'h0);
        for (int k = 1; k <= 4; k++) od(1'h0, DSFS_IDX_FBSEL, k[7:0], 32'h0, 1'h0);
        od(1'h0, DSFS_IDX_SUBMODE, 8'h00, 32'h0, 1'h0);
        od(1'h1, DSFS_IDX_FBSEL, 8'h00, 32'h9, 1'h1);
        od(1'h0, DSFS_IDX_FBSEL, 8'h05, 32'h0, 1'h1);
        wfb(8'h01, 32'h1a5);
        od(1'h0, DSFS_IDX_FBSEL, 8'h01, 32'ha5, 1'h0);
        chk(fb_src_o, 24'h010101);
    endtask : t_regs

    task automatic t_modes();
        wsm(32'h4e);
        torque_mode_i = 1'h1;
        step(3);
        chk(mode_o, 8'h76);
        wsm(32'h20);
        step(3);
        chk(mode_o, 8'h08);
        torque_mode_i = 1'h0;
        step(3);
        chk(mode_o, 8'h00);
    endtask : t_modes

    task automatic t_close(input logic al, input logic hidx);
        comm_has_index_i = hidx;
        wsm({27'h0, al, 4'h1});
        enable(1'h1);
        chk(align_req_o, al | !hidx);
        chk(mode_o.loop_closed, 1'h0);
        align_done_i = al | !hidx;
        index_seen_i = !(al | !hidx);
        step(1);
        align_done_i = 1'h0;
        index_seen_i = 1'h0;
        step(2);
        chk({align_req_o, mode_o.loop_closed}, 2'h1);
        wsm(32'h88);
        step(3);
        chk(mode_o, 8'h81);
        enable(1'h0);
        chk(mode_o, 8'h10);
    endtask : t_close

    task automatic t_fb();
        wfb(8'h02, 32'h02);
        wfb(8'h03, 32'h05);
        wfb(8'h04, 32'h07);
        wsm(32'h11);
        enable(1'h1);
        chk(fb_src_o, 24'h030203);
        wfb(8'h02, 32'h07);
        step(3);
        chk(fb_src_o, 24'h030203);
        od(1'h0, DSFS_IDX_FBSEL, 8'h02, 32'h07, 1'h0);
        enable(1'h0);
        enable(1'h1);
        chk(fb_src_o, 24'h020202);
        enable(1'h0);
        wsm(32'h0);
        enable(1'h1);
        chk(fb_src_o, 24'h020201);
        enable(1'h0);
        for (int k = 2; k <= 4; k++) wfb(k[7:0], 32'h0);
        enable(1'h1);
        chk(fb_src_o, 24'h010101);
    endtask : t_fb

    initial begin
        od_req_i = '0;
        rst_n_i = 1'h0;
        op_enabled_i = 1'h0;
        torque_mode_i = 1'h0;
        comm_has_index_i = 1'h1;
        index_seen_i = 1'h0;
        align_done_i = 1'h0;
        step(16);
        rst_n_i = 1'h1;
        t_regs();
        t_modes();
        t_close(1'h1, 1'h1);
        t_close(1'h0, 1'h1);
        t_close(1'h0, 1'h0);
        t_fb();
        end_of_test();
    end
endmodule : tb_top

bind dsfs_top dsfs_chk #(.NUM_FB(NUM_FB)) i_dsfs_chk (.clk_sys_i, .rst_n_i, .od_req_i,
    .od_rsp_o, .op_enabled_i, .torque_mode_i, .comm_has_index_i, .index_seen_i,
    .align_done_i, .mode_o, .align_req_o, .fb_src_o);
